// file: tb/tb_uart_rx_recovery_addr_filter.sv
// Testbench joining the transmitting party to the recovering receiver.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_rx_recovery_addr_filter;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic send_in = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic ninth_in = 1'b0;
  logic two_stop_in = 1'b0;
  logic [2:0] size_in = 3'h3;
  logic filter_in = 1'b0;
  logic rx_read_in = 1'b0;
  logic reader_on = 1'b1;
  logic dbl_in = 1'b0;
  logic busy_out, flag_out, ninth_out, fe_out, overrun_out;
  logic [7:0] data_out;
  logic [19:0] note;
  logic [19:0] notes[$];
  logic [31:0] rng = 32'hf8db2650;
  int mismatches = 0;
  int checks = 0;
  int cool = 0;
  int test_no = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  uart_link_if uart_link_if_i ();
  uart_peer_tx uart_peer_tx_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(uart_link_if_i),
    .send_in(send_in), .data_in(data_in), .tx_ninth_bit_in(ninth_in), .two_stop_select_in(two_stop_in),
    .char_size_select_in(size_in), .double_speed_select_in(dbl_in), .busy_out(busy_out));
  uart_rx_recovery uart_rx_recovery_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(uart_link_if_i),
    .double_speed_select_in(dbl_in), .address_filter_mode_in(filter_in), .char_size_select_in(size_in),
    .rx_complete_flag_out(flag_out), .data_buffer_port_out(data_out), .rx_ninth_bit_out(ninth_out),
    .frame_error_flag_out(fe_out), .rx_read_in(rx_read_in), .overrun_out(overrun_out));
  uart_link_sva uart_link_sva_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .serial_line(uart_link_if_i.serial_line), .tx_sample_tick(uart_link_if_i.tx_sample_tick),
    .busy_out(busy_out), .rx_complete_flag_out(flag_out), .rx_read_in(rx_read_in), .overrun_out(overrun_out));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0) begin
      @(negedge clk_sys_in);
      n++;
      if (n > 9000) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_idle
  // A frame sent with keep clear is left out of the notes, as the receiver must not deliver it.
  task automatic send(input logic [7:0] d, input logic nb, input logic keep);
    logic [7:0] m;
    logic nine;
    m = 8'hff >> (2'h3 - size_in[1:0]);
    nine = (size_in == 3'h7);
    wait_idle();
    send_in = 1'b1;
    data_in = d;
    ninth_in = nb;
    if (keep) begin
      notes.push_back({1'b1, nine, m, 1'b0, nb & nine, d & m});
    end
    @(negedge clk_sys_in);
    send_in = 1'b0;
    @(negedge clk_sys_in);
  endtask : send
  task automatic drain;
    int n;
    wait_idle();
    n = 0;
    while (notes.size() != 0 || flag_out !== 1'b0) begin
      @(negedge clk_sys_in);
      n++;
      if (n > 9000) begin
        mismatches++;
        report_and_stop();
      end
    end
    test_no++;
    $display("test %0d done", test_no);
  endtask : drain
  // Reads wait a few clocks after each pop because the outputs lag the buffer.
  always @(negedge clk_sys_in) begin : reader
    logic rd;
    rd = 1'b0;
    if (cool > 0) begin
      cool--;
    end else if (reader_on && flag_out === 1'b1) begin
      if (notes.size() == 0) begin
        chk(10'h3ff, 10'h000);
      end else begin
        note = notes.pop_front();
        chk({fe_out, ninth_out, data_out}, note[9:0]);
      end
      rd = 1'b1;
      cool = 4;
    end
    rx_read_in = rd;
  end
  initial begin
    repeat (6) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      send(rng[7:0], 1'b0, 1'b1);
    end
    drain();
    dbl_in = 1'b1;
    for (int i = 0; i < 2; i++) begin
      rng = xs(rng);
      send(rng[7:0], 1'b0, 1'b1);
    end
    drain();
    dbl_in = 1'b0;
    size_in = 3'h7;
    filter_in = 1'b1;
    rng = xs(rng);
    send(rng[7:0], 1'b0, 1'b0);
    send(rng[15:8], 1'b1, 1'b1);
    drain();
    filter_in = 1'b0;
    send(rng[23:16], 1'b0, 1'b1);
    drain();
    two_stop_in = 1'b1;
    filter_in = 1'b1;
    for (int s = 0; s < 4; s++) begin
      size_in = 3'(s);
      rng = xs(rng);
      send(rng[7:0], 1'b0, 1'b1);
      drain();
    end
    two_stop_in = 1'b0;
    filter_in = 1'b0;
    reader_on = 1'b0;
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      send(rng[7:0], 1'b0, i < 2);
    end
    wait_idle();
    for (int n = 0; n < 3000 && overrun_out !== 1'b1; n++) begin
      @(negedge clk_sys_in);
    end
    chk({9'h000, overrun_out}, 10'h001);
    reader_on = 1'b1;
    drain();
    chk({9'h000, flag_out}, 10'h000);
    report_and_stop();
  end
endmodule : tb_uart_rx_recovery_addr_filter
`default_nettype wire

// file: tb/uart_link_sva.sv
// Checker for the serial link and the receiver's buffer flags.
`timescale 1ns/1ps
`default_nettype none
module uart_link_sva (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Link and flags
  input wire logic serial_line,
  input wire logic tx_sample_tick,
  input wire logic busy_out,
  input wire logic rx_complete_flag_out,
  input wire logic rx_read_in,
  input wire logic overrun_out
);
  localparam int LOW_GAP_MAX = 8000;
  logic [15:0] since_low_ff;
  // Saturating count of clocks since the line was last low, so that a flag cannot rise out of nothing.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || !serial_line) begin
      since_low_ff <= 16'h0000;
    end else if (since_low_ff != 16'hffff) begin
      since_low_ff <= since_low_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_start_edge;
    $fell(serial_line);
  endsequence
  sequence s_start_held;
    (!serial_line) [*8];
  endsequence
  a_idle_in_reset: assert property (disable iff (1'b0) !rstn_in |=> serial_line)
    else $error("line not idle high after reset");
  a_start_bit_held: assert property (s_start_edge |-> s_start_held)
    else $error("start bit shorter than eight clocks");
  a_bit_level_stable: assert property ($changed(serial_line) |=> $stable(serial_line) [*8])
    else $error("line level changed within a bit");
  a_edge_on_tick: assert property ($changed(serial_line) |->
      tx_sample_tick || $past(tx_sample_tick) || $past(tx_sample_tick, 2))
    else $error("line changed away from a sample tick");
  a_tick_is_pulse: assert property (tx_sample_tick |=> !tx_sample_tick [*8])
    else $error("sample ticks too close together");
  a_idle_when_free: assert property (!busy_out && $past(!busy_out) |-> serial_line)
    else $error("line low while transmitter idle");
  a_flag_stands: assert property (rx_complete_flag_out && !rx_read_in && !$past(rx_read_in)
      && !$past(rx_read_in, 2) |=> rx_complete_flag_out)
    else $error("receive flag dropped without a read");
  a_overrun_needs_full: assert property ($rose(overrun_out) |-> rx_complete_flag_out)
    else $error("overrun raised with empty buffer");
  a_flag_after_frame: assert property ($rose(rx_complete_flag_out) |-> since_low_ff < LOW_GAP_MAX)
    else $error("receive flag rose with no frame on the line");
endmodule : uart_link_sva
`default_nettype wire

// file: verilog/rx_frame_buffer.sv
// Two-entry frame buffer holding data with its frame error flag.
`timescale 1ns/1ps
`default_nettype none
module rx_frame_buffer (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [9:0] in_word_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [9:0] out_word_out
);
  logic [9:0] slot_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_out = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_word_out = slot_ff[rd_ptr_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      slot_ff[wr_ptr_ff] <= in_word_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wr_ptr_ff <= 1'h0;
      rd_ptr_ff <= 1'h0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + 2'(push) - 2'(pop);
    end
  end
endmodule : rx_frame_buffer
`default_nettype wire

// file: verilog/uart_link_if.sv
// Serial link between the transmitting party and the recovering receiver.
`timescale 1ns/1ps
`default_nettype none
interface uart_link_if;
  logic serial_line;
  logic tx_sample_tick;
  modport peer_end (output serial_line, output tx_sample_tick);
  modport rx_end (input serial_line);
endinterface : uart_link_if
`default_nettype wire

// file: verilog/uart_peer_tx.sv
// Far end: transmitting party sending address and data frames on the link.
`timescale 1ns/1ps
`default_nettype none
module uart_peer_tx (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Serial link
  uart_link_if.peer_end link,
  // Frame request
  input wire logic send_in,
  input wire logic [7:0] data_in,
  input wire logic tx_ninth_bit_in,
  input wire logic two_stop_select_in,
  input wire logic [2:0] char_size_select_in,
  input wire logic double_speed_select_in,
  output logic busy_out
);
  logic [15:0] div_ff;
  logic [3:0] sub_ff;
  logic [12:0] frame_ff;
  logic [3:0] left_ff;
  logic baud;
  logic [3:0] nbits;
  logic [12:0] word;

  assign nbits = (char_size_select_in == uart_rx_pkg::CHAR_SIZE_NINE) ? uart_rx_pkg::CHAR_BITS_NINE
                                                                     : ({1'b0, char_size_select_in} + 4'h5);
  // Eight sub-ticks per bit in double speed, sixteen otherwise.
  assign baud = (div_ff == uart_rx_pkg::TICK_DIV - 16'h0001)
                && (double_speed_select_in ? (sub_ff[2:0] == 3'h7) : (sub_ff == 4'hf));
  assign word = ({4'hf, tx_ninth_bit_in, data_in} & ~(13'h1fff << nbits)) | (13'h1fff << nbits);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      div_ff <= 16'h0000;
      sub_ff <= 4'h0;
    end else if (div_ff == uart_rx_pkg::TICK_DIV - 16'h0001) begin
      div_ff <= 16'h0000;
      sub_ff <= sub_ff + 4'h1;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // The ninth bit is sent set only for address frames; short frames rely on a second stop bit.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      frame_ff <= 13'h1fff;
      left_ff <= 4'h0;
      busy_out <= 1'b0;
    end else if (!busy_out && send_in) begin
      busy_out <= 1'b1;
      // Bit 0 keeps the line idle until the next baud tick, so the start bit is a full bit long.
      frame_ff <= {word[10:0], 2'b01};
      left_ff <= nbits + 4'h3 + {3'h0, two_stop_select_in};
    end else if (busy_out && baud) begin
      frame_ff <= {1'b1, frame_ff[12:1]};
      left_ff <= left_ff - 4'h1;
      busy_out <= (left_ff != 4'h1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      link.serial_line <= uart_rx_pkg::IDLE_LEVEL;
      link.tx_sample_tick <= 1'b0;
    end else begin
      link.serial_line <= busy_out ? frame_ff[0] : uart_rx_pkg::IDLE_LEVEL;
      link.tx_sample_tick <= baud;
    end
  end
endmodule : uart_peer_tx
`default_nettype wire

// file: verilog/uart_rx_pkg.sv
// Package with timing, frame and sampling constants for the recovering receiver.
package uart_rx_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_HZ = 115200;
  // Sample tick period in system clocks for the 16x rate; the 8x rate doubles the bit rate.
  localparam logic [15:0] TICK_DIV = 16'(CLK_HZ / (BAUD_HZ * 16));
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
  localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [2:0] CHAR_SIZE_RESET = 3'h3;
  localparam logic [0:0] IDLE_LEVEL = 1'h1;
endpackage : uart_rx_pkg

// file: verilog/uart_rx_recovery.sv
// Receiver end: start validation, oversampled majority recovery and address filtering.
// What this block does
// - 16 sample states per bit, 8 in double speed.
// - Decide each bit by voting three centre samples.
// - Vote from sample 8, or 4 double speed.
// - Two or more high gives 1, else 0.
// - Recover through first stop bit, ignore the rest.
// - Stop bit voted zero sets frame error flag.
// - Accept next start right after last stop vote.
// - Normal mode tolerates 95.36 to 104.58 percent.
// - Double speed tolerates 96.00 to 103.90 percent.
// - Filter mode discards frames without address indication.
// - Transmitter unaffected by address filter mode.
// - Five to eight bits: stop bit marks address.
// - Nine bits: ninth bit marks address.
// - Indicator one is address, zero is data.
// - Address frames stored and flagged as normal.
// - Master sets ninth bit only for addresses.
// - Software clears filter on match, sets after data.
// - Filtered short frames need two stop bits.
// - Software avoids read-modify-write on filter bit.
// - Start validated by votes at 8-10 or 4-6.
// - Double speed halves samples per bit.
// - Frame error flag travels with its frame.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recovery (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Serial link
  uart_link_if.rx_end link,
  // Configuration
  input wire logic double_speed_select_in,
  input wire logic address_filter_mode_in,
  input wire logic [2:0] char_size_select_in,
  // Received frames
  output logic rx_complete_flag_out,
  output logic [7:0] data_buffer_port_out,
  output logic rx_ninth_bit_out,
  output logic frame_error_flag_out,
  input wire logic rx_read_in,
  output logic overrun_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BITS = 2'b10
  } rx_state_e;

  rx_state_e state_ff;
  logic [1:0] sync_ff;
  logic [15:0] div_ff;
  logic tick;
  logic [4:0] sample_ff;
  logic [2:0] votes_ff;
  logic [3:0] bit_idx_ff;
  logic [8:0] shift_ff;
  logic push_ff;
  logic [9:0] push_word_ff;
  logic buf_ready;
  logic buf_valid;
  logic [9:0] buf_word;
  logic overrun_ff;
  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [3:0] char_bits;
  logic bit_done;
  logic voted;
  logic indicator;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  // Nine-bit frames use the top size code; the other codes count up from five data bits.
  function automatic logic [3:0] char_bits_of(input logic [2:0] size);
    if (size == uart_rx_pkg::CHAR_SIZE_NINE) begin
      char_bits_of = uart_rx_pkg::CHAR_BITS_NINE;
    end else begin
      char_bits_of = {1'b0, size} + 4'h5;
    end
  endfunction : char_bits_of

  // Pin passes two flip-flops before any logic reads it.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sync_ff <= {2{uart_rx_pkg::IDLE_LEVEL}};
    end else begin
      sync_ff <= {sync_ff[0], link.serial_line};
    end
  end

  // Divisor stays the same in double speed; the bit rate doubles because a bit is only 8 samples.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign tick = (div_ff == uart_rx_pkg::TICK_DIV - 16'h0001);

  assign spb = double_speed_select_in ? uart_rx_pkg::SAMPLES_DOUBLE : uart_rx_pkg::SAMPLES_NORMAL;
  assign vote_first = double_speed_select_in ? uart_rx_pkg::VOTE_FIRST_DOUBLE
                                             : uart_rx_pkg::VOTE_FIRST_NORMAL;
  assign char_bits = char_bits_of(char_size_select_in);
  assign bit_done = tick && (sample_ff == vote_first + 5'h02);
  assign voted = majority({votes_ff[1:0], sync_ff[1]});

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_ff <= ST_IDLE;
      sample_ff <= 5'h00;
      votes_ff <= 3'h0;
      bit_idx_ff <= 4'h0;
      shift_ff <= 9'h000;
      push_ff <= 1'b0;
      push_word_ff <= 10'h000;
    end else begin
      push_ff <= 1'b0;
      if (tick) begin
        votes_ff <= {votes_ff[1:0], sync_ff[1]};
      end
      unique case (state_ff)
        ST_IDLE: begin
          if (tick && !sync_ff[1]) begin
            state_ff <= ST_START;
            sample_ff <= 5'h02;
          end
        end
        ST_START: begin
          if (tick) begin
            sample_ff <= sample_ff + 5'h01;
            if (bit_done) begin
              if (voted) begin
                state_ff <= ST_IDLE;
              end else begin
                state_ff <= ST_BITS;
                bit_idx_ff <= 4'h0;
                shift_ff <= 9'h000;
                // Continue counting from the sample after the start vote, so later votes land mid-bit.
                sample_ff <= vote_first + 5'h03;
              end
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            sample_ff <= (sample_ff == spb) ? 5'h01 : sample_ff + 5'h01;
            if (bit_done) begin
              if (bit_idx_ff == char_bits) begin
                // Early return to idle lets the next start edge be seen at once.
                state_ff <= ST_IDLE;
                push_word_ff <= {~voted, shift_ff};
                push_ff <= !address_filter_mode_in || indicator;
              end else begin
                // Bits land LSB first at their own index; unused upper bits stay zero.
                shift_ff[bit_idx_ff] <= voted;
                bit_idx_ff <= bit_idx_ff + 4'h1;
              end
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // A frame arriving with the buffer full is lost and flagged, never stored.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      overrun_ff <= 1'b0;
    end else if (push_ff && !buf_ready) begin
      overrun_ff <= 1'b1;
    end else if (push_ff) begin
      overrun_ff <= 1'b0;
    end
  end

  rx_frame_buffer u_buf (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .in_valid_in(push_ff),
    .in_ready_out(buf_ready),
    .in_word_in(push_word_ff),
    .out_valid_out(buf_valid),
    .out_ready_in(rx_read_in),
    .out_word_out(buf_word)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rx_complete_flag_out <= 1'b0;
      data_buffer_port_out <= 8'h00;
      rx_ninth_bit_out <= 1'b0;
      frame_error_flag_out <= 1'b0;
      overrun_out <= 1'b0;
    end else begin
      rx_complete_flag_out <= buf_valid;
      data_buffer_port_out <= buf_word[7:0];
      rx_ninth_bit_out <= buf_word[8];
      frame_error_flag_out <= buf_valid && buf_word[9];
      overrun_out <= overrun_ff;
    end
  end
  // Short frames carry the frame type in the first stop bit, nine-bit frames in the ninth bit.
  assign indicator = (char_bits == uart_rx_pkg::CHAR_BITS_NINE) ? shift_ff[8] : voted;
endmodule : uart_rx_recovery
`default_nettype wire
